/* File: irqx_pkg.sv */
// Purpose: Shared constants and types for the interrupt-return and config-load execution block.
// Assumes: 14-bit instruction words, 8-bit data, four quarter phases per instruction cycle.
// Notes:   All numbers used by more than one file live here.
package irqx_pkg;
    localparam logic [13:0] IRQ_RETURN_OP    = 14'h0009;
    localparam logic [13:0] CFG_LOAD_OP      = 14'h0062;
    localparam int          GLOBAL_IRQ_ENABLE_BIT = 7;
    localparam logic [7:0]  IRQ_CTRL_RESET   = 8'h00;
    localparam logic [7:0]  CFG_RESET        = 8'hFF;
    localparam logic [12:0] PC_RESET         = 13'h0000;
    localparam logic [1:0]  Q1               = 2'h0;
    localparam logic [1:0]  Q2               = 2'h1;
    localparam logic [1:0]  Q3               = 2'h2;
    localparam logic [1:0]  Q4               = 2'h3;

    typedef enum logic [1:0] {
        IRQX_IDLE  = 2'b00,
        IRQX_RET1  = 2'b01,
        IRQX_FLUSH = 2'b10
    } irqx_state_t;
endpackage

/* File: irqx_phase_if.sv */
// Purpose: Carries the quarter-phase count from the phase generator to the executor.
// Assumes: One phase step per clock.
// Notes:   Phase 0 is the decode quarter.
`timescale 1ns/10ps
`default_nettype none
interface irqx_phase_if;
    logic [1:0] quarter;
    logic       cycle_start;
    modport gen  (output quarter, output cycle_start);
    modport exec (input quarter, input cycle_start);
endinterface
`default_nettype wire

/* File: irqx_phase_gen.sv */
// Purpose: Generates the four quarter phases of the instruction cycle.
// Assumes: Each rising i_mclk edge advances one quarter.
// Notes:   cycle_start marks the decode quarter.
`timescale 1ns/10ps
`default_nettype none
module irqx_phase_gen
(
    input  wire logic  i_mclk,
    input  wire logic  i_reset,
    irqx_phase_if.gen  ph
);
    typedef struct packed {
        logic [1:0] q;
    } irqx_phase_t;

    irqx_phase_t s_q;
    irqx_phase_t s_d;

    always_comb
    begin
        s_d   = s_q;
        s_d.q = s_q.q + 2'h1;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            s_q.q <= irqx_pkg::Q1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign ph.quarter     = s_q.q;
    assign ph.cycle_start = (s_q.q == irqx_pkg::Q1);
endmodule // irqx_phase_gen
`default_nettype wire

/* File: irqx_exec.sv */
// What this block does
// - Decode word 0x0009 as interrupt return, flags untouched.
// - Interrupt return pops stack into program counter.
// - Set enable bit 7 in Q3, pop Q4.
// - Two cycles; second cycle discards fetched instruction.
// - Decode 0x0062; copy accumulator to config, one cycle.
//
// Purpose: Executes the interrupt-return and legacy config-load instructions.
// Assumes: i_instr holds the word being decoded and is stable across its cycle.
// Notes:   Stack storage and the rest of the instruction set live outside.
`timescale 1ns/10ps
`default_nettype none
module irqx_exec
(
    input  wire logic        i_mclk,
    input  wire logic        i_reset,
    input  wire logic [13:0] i_instr,
    input  wire logic        i_instr_valid,
    input  wire logic [12:0] i_stack_top_entry,
    input  wire logic [7:0]  i_accum,
    input  wire logic        i_irq_ctrl_wr,
    input  wire logic [7:0]  i_irq_ctrl_wdata,
    output logic      [7:0]  o_irq_control_reg,
    output logic      [7:0]  o_cfg_reg,
    output logic      [12:0] o_pc_load_value,
    output logic             o_pc_load,
    output logic             o_stack_pop,
    output logic             o_flush,
    output logic             o_quarter_start
);
    typedef struct packed {
        irqx_pkg::irqx_state_t st;
        logic [7:0]            irq_ctrl;
        logic [7:0]            cfg;
        logic [12:0]           pc_val;
        logic                  pc_load;
        logic                  pop;
        logic                  flush;
        logic                  qstart;
    } irqx_exec_t;

    irqx_exec_t   s_q;
    irqx_exec_t   s_d;
    irqx_phase_if ph();

    irqx_phase_gen u_phase
    (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .ph      (ph)
    );

    logic is_ret;
    logic is_cfg;

    assign is_ret = i_instr_valid && (i_instr == irqx_pkg::IRQ_RETURN_OP);
    assign is_cfg = i_instr_valid && (i_instr == irqx_pkg::CFG_LOAD_OP);

    always_comb
    begin
        s_d         = s_q;
        s_d.pc_load = 1'b0;
        s_d.pop     = 1'b0;
        // The marker lags Q1 by one clock so that it leaves a flip-flop directly.
        s_d.qstart  = ph.cycle_start;
        // Software writes to the control register apply first so the hardware set wins.
        if (i_irq_ctrl_wr)
        begin
            s_d.irq_ctrl = i_irq_ctrl_wdata;
        end
        // Only the idle state decodes, so a word fetched during a return is dropped.
        case (s_q.st)
            irqx_pkg::IRQX_IDLE:
            begin
                s_d.flush = 1'b0;
                if (ph.quarter == irqx_pkg::Q1 && is_ret)
                begin
                    s_d.st = irqx_pkg::IRQX_RET1;
                end
                if (ph.quarter == irqx_pkg::Q4 && is_cfg)
                begin
                    s_d.cfg = i_accum;
                end
            end
            irqx_pkg::IRQX_RET1:
            begin
                // enable bit set in third quarter
                if (ph.quarter == irqx_pkg::Q3)
                begin
                    s_d.irq_ctrl[irqx_pkg::GLOBAL_IRQ_ENABLE_BIT] = 1'b1;
                end
                if (ph.quarter == irqx_pkg::Q4)
                begin
                    s_d.pop     = 1'b1;
                    s_d.pc_load = 1'b1;
                    s_d.pc_val  = i_stack_top_entry;
                    s_d.flush   = 1'b1;
                    s_d.st      = irqx_pkg::IRQX_FLUSH;
                end
            end
            irqx_pkg::IRQX_FLUSH:
            begin
                if (ph.quarter == irqx_pkg::Q4)
                begin
                    s_d.flush = 1'b0;
                    s_d.st    = irqx_pkg::IRQX_IDLE;
                end
            end
            default:
            begin
                s_d.st    = irqx_pkg::IRQX_IDLE;
                s_d.flush = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            s_q.st       <= irqx_pkg::IRQX_IDLE;
            s_q.irq_ctrl <= irqx_pkg::IRQ_CTRL_RESET;
            s_q.cfg      <= irqx_pkg::CFG_RESET;
            s_q.pc_val   <= irqx_pkg::PC_RESET;
            s_q.pc_load  <= 1'b0;
            s_q.pop      <= 1'b0;
            s_q.flush    <= 1'b0;
            s_q.qstart   <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_irq_control_reg = s_q.irq_ctrl;
    assign o_cfg_reg         = s_q.cfg;
    assign o_pc_load_value   = s_q.pc_val;
    assign o_pc_load         = s_q.pc_load;
    assign o_stack_pop       = s_q.pop;
    assign o_flush           = s_q.flush;
    assign o_quarter_start   = s_q.qstart;

    // Note: the return word is matched in the decode quarter and the config word in Q4; later quarters act on state.
    // return entry
    ret_enter_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        (ph.quarter == irqx_pkg::Q1 && is_ret && s_q.st == irqx_pkg::IRQX_IDLE)
        |=> s_q.st == irqx_pkg::IRQX_RET1)
        else $error("Return word not accepted.");
    pop_load_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        o_stack_pop |-> o_pc_load && o_flush)
        else $error("Pop without program counter load.");
    pop_value_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        (s_q.st == irqx_pkg::IRQX_RET1 && ph.quarter == irqx_pkg::Q4)
        |=> o_pc_load_value == $past(i_stack_top_entry))
        else $error("Program counter got wrong stack value.");
    enable_set_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        (s_q.st == irqx_pkg::IRQX_RET1 && ph.quarter == irqx_pkg::Q3)
        |=> o_irq_control_reg[irqx_pkg::GLOBAL_IRQ_ENABLE_BIT])
        else $error("Enable bit not set in third quarter.");
    enable_before_pop_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        o_stack_pop |-> $past(o_irq_control_reg[irqx_pkg::GLOBAL_IRQ_ENABLE_BIT])
        || $past(i_irq_ctrl_wr, 2))
        else $error("Pop came before enable bit set.");
    two_cycle_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        $rose(o_flush) |-> o_flush [*4] ##1 !o_flush)
        else $error("Flush cycle length wrong.");
    no_pop_flush_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        $rose(o_flush) |=> !o_stack_pop [*3])
        else $error("Second cycle was not idle.");
    cfg_copy_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        (s_q.st == irqx_pkg::IRQX_IDLE && ph.quarter == irqx_pkg::Q4 && is_cfg)
        |=> o_cfg_reg == $past(i_accum))
        else $error("Config not loaded from accumulator.");
    cfg_hold_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        !(ph.quarter == irqx_pkg::Q4 && is_cfg) |=> $stable(o_cfg_reg))
        else $error("Config changed without the load word.");

    ret_refuse_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        (s_q.st == irqx_pkg::IRQX_IDLE && !(ph.quarter == irqx_pkg::Q1 && is_ret))
        |=> s_q.st == irqx_pkg::IRQX_IDLE)
        else $error("Return state entered without the return word.");
    pop_pulse_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        o_stack_pop |=> !o_stack_pop)
        else $error("Stack pop lasted more than one clock.");
    load_origin_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        o_pc_load |-> $past(s_q.st == irqx_pkg::IRQX_RET1 && ph.quarter == irqx_pkg::Q4))
        else $error("Program counter load outside a return.");
    ctrl_hold_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        (!i_irq_ctrl_wr && !(s_q.st == irqx_pkg::IRQX_RET1 && ph.quarter == irqx_pkg::Q3))
        |=> $stable(o_irq_control_reg))
        else $error("Control register changed without a write or return.");
    flush_no_load_a: assert property (@(posedge i_mclk) disable iff (i_reset)
        (s_q.st == irqx_pkg::IRQX_FLUSH) |=> $stable(o_cfg_reg) && !o_stack_pop)
        else $error("Discarded word acted during the no-operation cycle.");

    // Covers show that each main scenario is reached at least once.
    ret_seen_c: cover property (@(posedge i_mclk) disable iff (i_reset) o_stack_pop);
    cfg_seen_c: cover property (@(posedge i_mclk) disable iff (i_reset)
        ph.quarter == irqx_pkg::Q4 && is_cfg);
    clash_c: cover property (@(posedge i_mclk) disable iff (i_reset)
        s_q.st == irqx_pkg::IRQX_RET1 && ph.quarter == irqx_pkg::Q3 && i_irq_ctrl_wr);
    flush_end_c: cover property (@(posedge i_mclk) disable iff (i_reset)
        $fell(o_flush));
    ctrl_write_c: cover property (@(posedge i_mclk) disable iff (i_reset)
        i_irq_ctrl_wr);
endmodule // irqx_exec
`default_nettype wire

/* File: test_irq_return_and_cfg_load_exec.sv */
// Purpose: Self-checking bench for the interrupt-return and config-load executor.
// Assumes: Quarters run freely from reset; o_quarter_start is high during Q2.
// Notes:   Each operation is sampled for eight clocks after its Q1 edge.
`timescale 1ns/10ps
`default_nettype none
module test_irq_return_and_cfg_load_exec;
    logic        i_mclk            = 1'b0;
    logic        i_reset           = 1'b1;
    logic [13:0] i_instr           = 14'h0000;
    logic        i_instr_valid     = 1'b0;
    logic [12:0] i_stack_top_entry = 13'h0000;
    logic [7:0]  i_accum           = 8'h00;
    logic        i_irq_ctrl_wr     = 1'b0;
    logic [7:0]  i_irq_ctrl_wdata  = 8'h00;
    logic [7:0]  o_irq_control_reg;
    logic [7:0]  o_cfg_reg;
    logic [12:0] o_pc_load_value;
    logic        o_pc_load;
    logic        o_stack_pop;
    logic        o_flush;
    logic        o_quarter_start;
    int          mismatches        = 0;
    int          n_compared        = 0;
    int          cycles            = 0;
    logic [7:0]  s_ctrl [1:8];
    logic [7:0]  s_cfg  [1:8];
    logic        s_pop  [1:8];
    logic        s_load [1:8];
    logic        s_flush[1:8];
    logic        s_qst  [1:8];
    logic [12:0] s_pc;

    irqx_exec u_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_instr(i_instr),
        .i_instr_valid(i_instr_valid), .i_stack_top_entry(i_stack_top_entry),
        .i_accum(i_accum), .i_irq_ctrl_wr(i_irq_ctrl_wr), .i_irq_ctrl_wdata(i_irq_ctrl_wdata),
        .o_irq_control_reg(o_irq_control_reg), .o_cfg_reg(o_cfg_reg),
        .o_pc_load_value(o_pc_load_value), .o_pc_load(o_pc_load), .o_stack_pop(o_stack_pop),
        .o_flush(o_flush), .o_quarter_start(o_quarter_start));

    always #12.5 i_mclk = ~i_mclk;

    // The whole run needs well under a thousand clocks; a hang stops here.
    always @(posedge i_mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (mismatches == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Aligns to Q1, presents word, swaps to late at the fourth edge, idles at the eighth.
    task automatic run_op(input logic [13:0] word, input logic valid, input logic [13:0] late);
        int n;
        n = 0;
        do
        begin
            @(posedge i_mclk);
            #1;
            n++;
        end while (o_quarter_start !== 1'b1 && n < 8);
        repeat (3) @(posedge i_mclk);
        i_instr       <= word;
        i_instr_valid <= valid;
        for (int k = 1; k <= 8; k++)
        begin
            @(posedge i_mclk);
            if (k == 4)
                i_instr <= late;
            if (k == 8)
            begin
                i_instr       <= 14'h0000;
                i_instr_valid <= 1'b1;
            end
            #1;
            s_ctrl[k]  = o_irq_control_reg;
            s_cfg[k]   = o_cfg_reg;
            s_pop[k]   = o_stack_pop;
            s_load[k]  = o_pc_load;
            s_flush[k] = o_flush;
            s_qst[k]   = o_quarter_start;
            if (k == 4)
                s_pc = o_pc_load_value;
        end
    endtask

    task automatic sw_write(input logic [7:0] value);
        @(posedge i_mclk);
        i_irq_ctrl_wr    <= 1'b1;
        i_irq_ctrl_wdata <= value;
        @(posedge i_mclk);
        i_irq_ctrl_wr    <= 1'b0;
        #1;
        check("ctrl_write", {8'h00, o_irq_control_reg}, {8'h00, value});
    endtask

    task automatic t_return();
        @(posedge i_mclk);
        i_stack_top_entry <= 13'h1ABC;
        i_accum           <= 8'h77;
        // A config word during the flush cycle must be discarded.
        run_op(irqx_pkg::IRQ_RETURN_OP, 1'b1, irqx_pkg::CFG_LOAD_OP);
        check("enable_c2", {15'h0000, s_ctrl[2][irqx_pkg::GLOBAL_IRQ_ENABLE_BIT]},
              16'h0000);
        check("enable_c3", {8'h00, s_ctrl[3]}, 16'h00BC);
        check("pop_c3", {14'h0000, s_pop[3], s_load[3]}, 16'h0000);
        check("pop_c4", {14'h0000, s_pop[4], s_load[4]}, 16'h0003);
        check("pc_value", {3'h0, s_pc}, 16'h1ABC);
        check("pop_c5", {14'h0000, s_pop[5], s_load[5]}, 16'h0000);
        check("flush", {12'h000, s_flush[3], s_flush[4], s_flush[7], s_flush[8]}, 16'h0006);
        check("qstart", {12'h000, s_qst[1], s_qst[2], s_qst[4], s_qst[5]}, 16'h0009);
        check("cfg_kept", {8'h00, s_cfg[8]}, {8'h00, irqx_pkg::CFG_RESET});
    endtask

    task automatic t_config();
        @(posedge i_mclk);
        i_accum <= 8'h5A;
        run_op(irqx_pkg::CFG_LOAD_OP, 1'b1, 14'h0000);
        check("cfg_c3", {8'h00, s_cfg[3]}, {8'h00, irqx_pkg::CFG_RESET});
        check("cfg_c4", {8'h00, s_cfg[4]}, 16'h005A);
        check("cfg_side", {6'h00, s_ctrl[8], s_pop[4], s_flush[4]}, 16'h02F0);
    endtask

    task automatic t_ignored();
        sw_write(8'h00);
        // Neighbouring word and an invalid return word must do nothing.
        run_op(14'h0008, 1'b1, 14'h0000);
        check("near_word", {6'h00, s_ctrl[4], s_pop[4], s_flush[4]}, 16'h0000);
        run_op(irqx_pkg::IRQ_RETURN_OP, 1'b0, 14'h0000);
        check("not_valid", {6'h00, s_ctrl[4], s_pop[4], s_flush[4]}, 16'h0000);
    endtask

    initial
    begin
        repeat (16) @(posedge i_mclk);
        #1;
        check("reset_ctrl", {8'h00, o_irq_control_reg},
              {8'h00, irqx_pkg::IRQ_CTRL_RESET});
        check("reset_cfg", {8'h00, o_cfg_reg}, {8'h00, irqx_pkg::CFG_RESET});
        check("reset_pulses", {o_pc_load_value, o_pc_load, o_stack_pop, o_flush},
              16'h0000);
        check("reset_qstart", {15'h0000, o_quarter_start}, 16'h0000);
        @(posedge i_mclk);
        i_reset       <= 1'b0;
        i_instr_valid <= 1'b1;
        sw_write(8'h3C);
        t_return();
        t_config();
        t_ignored();
        give_verdict();
    end
endmodule // test_irq_return_and_cfg_load_exec
`default_nettype wire
